// ### verilog/uxf_top.sv
// uart extra features: sir ratio, rs-485 direction, tx/rx disable, multidrop receive
`timescale 1ns/100ps
// How it works
// - extra bit 7 picks sir pulse of 3/16 or 1/4 of a bit.
// - polarity bit 5 low: direction pin low sending, high receiving; high inverts.
// - with bit 4 set the transmitter owns the pin over modem bit and flow control.
// - pin goes low on a fifo write, high after the last bit leaves.
// - inverted: pin high while data waits, low after the last bit leaves.
// - transmit off idles the line after the current character; fifo keeps filling.
// - receive off stops reception at once, except in multidrop, and flushes the shifter into the fifo.
// - bit 0 low is plain uart, high is 9-bit multidrop.
// - in multidrop a parity of one marks an address character.
// - receiver off: data dropped; address flagged, pushed and reported.
// - a later address while on is flagged again; reception continues.
// - auto detect compares addresses with the pause-two value; drops the rest.
// - a matching address turns the receiver on, is pushed and reported.
// - later foreign address turns the receiver off; matches keep parity flag.
module uxf_top (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // transmit side of the uart core
  input wire logic core_txd,
  input wire logic baud16_tick,
  input wire logic tx_fifo_push,
  input wire logic tx_fifo_empty,
  input wire logic tx_shift_empty,
  input wire logic flow_rts_n,
  output logic tx_hold,
  // receive side of the uart core
  input wire logic char_valid,
  input wire logic [7:0] char_data,
  input wire logic char_parity,
  input wire logic char_pe,
  output logic rxd_core,
  output logic rx_enable,
  output logic rx_flush,
  output logic rx_push,
  output logic [7:0] rx_push_data,
  output logic rx_push_pe,
  output logic line_status_irq,
  // pins
  input wire logic rxd_pin,
  output logic txd_pin,
  output logic rts_n_pin
);
  typedef struct packed {
    logic [7:0] xfc;
    logic [7:0] pause2;
    logic [7:0] aux;
    logic wait_req;
    logic [31:0] rdata;
    logic [2:0] rx_sync;
    logic rxd;
    logic dir;
    logic rts_n;
    logic txd;
    logic tx_hold;
    logic rx_en;
    logic rx_flush;
  } uxf_top_s;
  uxf_top_s q;
  uxf_top_s d;
  logic gated_txd;

  uxf_link_if lk ();

  uxf_mdrop u_mdrop (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .lk(lk.filt)
  );

  uxf_sir_enc u_sir (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .lk(lk.enc)
  );

  function automatic logic at_ofs(input logic [3:0] addr, input logic [3:0] ofs);
    at_ofs = addr == ofs;
  endfunction : at_ofs

  function automatic logic [31:0] reg_read(input uxf_top_s s, input logic [3:0] addr);
    logic [7:0] stat;
    stat = 8'h00;
    stat[uxf_pkg::STAT_DIR] = s.dir;
    stat[uxf_pkg::STAT_RTS] = s.rts_n;
    stat[uxf_pkg::STAT_RX_ON] = !s.xfc[uxf_pkg::XFC_RX_OFF];
    stat[uxf_pkg::STAT_RXD] = s.rxd;
    if (at_ofs(addr, uxf_pkg::OFS_XFC))
      reg_read = {24'h000000, s.xfc};
    else if (at_ofs(addr, uxf_pkg::OFS_PAUSE2))
      reg_read = {24'h000000, s.pause2};
    else if (at_ofs(addr, uxf_pkg::OFS_AUX))
      reg_read = {24'h000000, s.aux};
    else if (at_ofs(addr, uxf_pkg::OFS_STAT))
      reg_read = {24'h000000, stat};
    else
      reg_read = 32'h00000000;
  endfunction : reg_read

  // the transmitter may only stop between characters
  assign gated_txd = (q.xfc[uxf_pkg::XFC_TX_OFF] && tx_shift_empty) ? 1'b1 : core_txd;

  // link feeds
  assign lk.ch_valid = char_valid;
  assign lk.ch_data = char_data;
  assign lk.ch_parity = char_parity;
  assign lk.ch_pe = char_pe;
  assign lk.multidrop = q.xfc[uxf_pkg::XFC_MULTIDROP];
  assign lk.special = q.aux[uxf_pkg::AUX_SPECIAL];
  assign lk.ls_ie = q.aux[uxf_pkg::AUX_LS_IE];
  assign lk.rx_on = !q.xfc[uxf_pkg::XFC_RX_OFF];
  assign lk.station = q.pause2;
  assign lk.sir_en = q.aux[uxf_pkg::AUX_IRDA_EN];
  assign lk.sir_fast = q.xfc[uxf_pkg::XFC_IRDA_FAST];
  assign lk.sir_tick = baud16_tick;
  assign lk.sir_txd = gated_txd;

  always_comb
  begin
    d = q;
    // bus: one wait cycle, answer in the next, write lands when waitrequest is seen low
    d.wait_req = 1'b1;
    if ((avs_read || avs_write) && q.wait_req)
    begin
      d.wait_req = 1'b0;
      d.rdata = avs_read ? reg_read(q, avs_address) : 32'h00000000;
    end
    if (avs_write && !q.wait_req && avs_byteenable[0])
    begin
      if (at_ofs(avs_address, uxf_pkg::OFS_XFC))
        d.xfc = avs_writedata[7:0] & uxf_pkg::XFC_WMASK;
      else if (at_ofs(avs_address, uxf_pkg::OFS_PAUSE2))
        d.pause2 = avs_writedata[7:0];
      else if (at_ofs(avs_address, uxf_pkg::OFS_AUX))
        d.aux = avs_writedata[7:0] & uxf_pkg::AUX_WMASK;
    end
    // address hardware overrides a software write in the same cycle
    if (lk.auto_on)
      d.xfc[uxf_pkg::XFC_RX_OFF] = 1'b0;
    if (lk.auto_off)
      d.xfc[uxf_pkg::XFC_RX_OFF] = 1'b1;
    // receive disable: stop now, push any partial shifter content once
    d.rx_flush = d.xfc[uxf_pkg::XFC_RX_OFF] && !q.xfc[uxf_pkg::XFC_RX_OFF];
    // multidrop keeps the core framing so addresses are still seen
    d.rx_en = !d.xfc[uxf_pkg::XFC_RX_OFF] || d.xfc[uxf_pkg::XFC_MULTIDROP];
    d.tx_hold = d.xfc[uxf_pkg::XFC_TX_OFF];
    // rx pin: three stages, accept a level once stages two and three agree
    d.rx_sync = {q.rx_sync[1:0], rxd_pin};
    if (q.rx_sync[2] == q.rx_sync[1])
      d.rxd = q.rx_sync[2];
    // direction activity: a new write wins over the empty indication
    if (tx_fifo_push)
      d.dir = 1'b1;
    else if (tx_fifo_empty && tx_shift_empty)
      d.dir = 1'b0;
    if (q.xfc[uxf_pkg::XFC_DIR_TX])
      d.rts_n = !q.dir ^ q.xfc[uxf_pkg::XFC_DIR_INV];
    else if (q.aux[uxf_pkg::AUX_HW_FLOW])
      d.rts_n = flow_rts_n;
    else
      d.rts_n = !q.aux[uxf_pkg::AUX_MCR_RTS];
    d.txd = q.aux[uxf_pkg::AUX_IRDA_EN] ? lk.sir_pulse : gated_txd;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      q <= '{xfc: uxf_pkg::XFC_RST,
             pause2: uxf_pkg::PAUSE2_RST,
             aux: uxf_pkg::AUX_RST,
             wait_req: 1'b1,
             rdata: 32'h00000000,
             rx_sync: uxf_pkg::SYNC_RST,
             rxd: 1'b1,
             dir: 1'b0,
             rts_n: 1'b1,
             txd: 1'b1,
             tx_hold: 1'b0,
             rx_en: 1'b1,
             rx_flush: 1'b0};
    else if (clk_en)
      q <= d;
  end

  // outputs
  assign avs_readdata = q.rdata;
  assign avs_waitrequest = q.wait_req;
  assign txd_pin = q.txd;
  assign rts_n_pin = q.rts_n;
  assign rxd_core = q.rxd;
  assign tx_hold = q.tx_hold;
  assign rx_enable = q.rx_en;
  assign rx_flush = q.rx_flush;
  assign rx_push = lk.push;
  assign rx_push_data = lk.push_data;
  assign rx_push_pe = lk.push_pe;
  assign line_status_irq = lk.ls_req;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  AST_DIR_POL: assert property (clk_en && q.xfc[uxf_pkg::XFC_DIR_TX]
    |=> rts_n_pin == ($past(!q.dir) ^ $past(q.xfc[uxf_pkg::XFC_DIR_INV])))
    else $error("direction pin polarity wrong");
  AST_FLOW_PASS: assert property (clk_en && !q.xfc[uxf_pkg::XFC_DIR_TX] && q.aux[uxf_pkg::AUX_HW_FLOW]
    |=> rts_n_pin == $past(flow_rts_n))
    else $error("flow control not passed to pin");
  AST_DIR_LOW: assert property (clk_en && tx_fifo_push && q.xfc[uxf_pkg::XFC_DIR_TX]
    && !q.xfc[uxf_pkg::XFC_DIR_INV] ##1 clk_en && q.xfc[uxf_pkg::XFC_DIR_TX] && !q.xfc[uxf_pkg::XFC_DIR_INV]
    |=> !rts_n_pin)
    else $error("direction pin not low after fifo write");
  AST_DIR_HIGH_INV: assert property (clk_en && tx_fifo_push && q.xfc[uxf_pkg::XFC_DIR_TX]
    && q.xfc[uxf_pkg::XFC_DIR_INV] ##1 clk_en && q.xfc[uxf_pkg::XFC_DIR_TX] && q.xfc[uxf_pkg::XFC_DIR_INV]
    |=> rts_n_pin)
    else $error("inverted direction pin not high after fifo write");
  AST_DIR_DONE: assert property (clk_en && q.dir && tx_fifo_empty && tx_shift_empty && !tx_fifo_push
    |=> !q.dir)
    else $error("direction not released after last bit");
  AST_TX_IDLE: assert property (clk_en && q.xfc[uxf_pkg::XFC_TX_OFF] && tx_shift_empty
    && !q.aux[uxf_pkg::AUX_IRDA_EN] |=> txd_pin)
    else $error("line not idle while transmitter off");
  AST_RX_FLUSH: assert property ($rose(q.xfc[uxf_pkg::XFC_RX_OFF]) |-> rx_flush && !rx_enable == !q.xfc[0])
    else $error("receive disable did not flush");
  AST_RSV_ZERO: assert property ((q.xfc & ~uxf_pkg::XFC_WMASK) == 8'h00)
    else $error("reserved bits set");
  AST_BUS_ANSWER: assert property (clk_en && (avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle");
  AST_HOLD_MIRROR: assert property (tx_hold == q.xfc[uxf_pkg::XFC_TX_OFF])
    else $error("transmit hold differs from control bit");
  AST_RX_EN: assert property (rx_enable == (!q.xfc[uxf_pkg::XFC_RX_OFF]
    || q.xfc[uxf_pkg::XFC_MULTIDROP]))
    else $error("receiver enable wrong");
  AST_TXD_FOLLOW: assert property (clk_en && !q.aux[uxf_pkg::AUX_IRDA_EN] |=> txd_pin == $past(gated_txd))
    else $error("line does not follow transmitter");
  AST_TXD_SIR: assert property (clk_en && q.aux[uxf_pkg::AUX_IRDA_EN] |=> txd_pin == $past(lk.sir_pulse))
    else $error("line does not carry sir pulse");
  AST_MCR_RTS: assert property (clk_en && !q.xfc[uxf_pkg::XFC_DIR_TX] && !q.aux[uxf_pkg::AUX_HW_FLOW]
    |=> rts_n_pin == !$past(q.aux[uxf_pkg::AUX_MCR_RTS]))
    else $error("modem rts bit not on pin");
  AST_FLUSH_ONCE: assert property (clk_en && rx_flush |=> !rx_flush)
    else $error("flush longer than one cycle");
  AST_WAIT_IDLE: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest dropped without request");
  AST_XFC_STABLE: assert property (clk_en && !avs_write && !lk.auto_on && !lk.auto_off |=> $stable(q.xfc))
    else $error("control register changed without cause");
  AST_DIR_SET: assert property (clk_en && tx_fifo_push |=> q.dir)
    else $error("fifo write did not mark direction");
  AST_RXD_KEEP: assert property (clk_en && q.rx_sync[2] != q.rx_sync[1] |=> $stable(rxd_core))
    else $error("rxd accepted before stages agree");
  AST_AUTO_CLEAR: assert property (clk_en && lk.auto_on |=> !q.xfc[uxf_pkg::XFC_RX_OFF])
    else $error("auto enable did not clear receive off");
  AST_AUTO_SET: assert property (clk_en && lk.auto_off |=> q.xfc[uxf_pkg::XFC_RX_OFF])
    else $error("auto disable did not set receive off");
  COV_BUS_WRITE: cover property (avs_write && !avs_waitrequest && at_ofs(avs_address, uxf_pkg::OFS_XFC));
  COV_DIR_CYCLE: cover property ($fell(rts_n_pin) ##[1:400] $rose(rts_n_pin));
endmodule : uxf_top

// ### verilog/uxf_pkg.sv
// shared constants of the uart extra-features block
package uxf_pkg;
  // register byte offsets on the avalon slave
  localparam logic [3:0] OFS_XFC = 4'h0;
  localparam logic [3:0] OFS_PAUSE2 = 4'h4;
  localparam logic [3:0] OFS_AUX = 4'h8;
  localparam logic [3:0] OFS_STAT = 4'hC;
  // extra_features_control fields
  localparam int XFC_IRDA_FAST = 7;
  localparam int XFC_DIR_INV = 5;
  localparam int XFC_DIR_TX = 4;
  localparam int XFC_TX_OFF = 2;
  localparam int XFC_RX_OFF = 1;
  localparam int XFC_MULTIDROP = 0;
  localparam logic [7:0] XFC_WMASK = 8'hB7;
  localparam logic [7:0] XFC_RST = 8'h00;
  // auxiliary control fields
  localparam int AUX_SPECIAL = 0;
  localparam int AUX_MCR_RTS = 1;
  localparam int AUX_HW_FLOW = 2;
  localparam int AUX_LS_IE = 3;
  localparam int AUX_IRDA_EN = 4;
  localparam logic [7:0] AUX_WMASK = 8'h1F;
  localparam logic [7:0] AUX_RST = 8'h00;
  localparam logic [7:0] PAUSE2_RST = 8'h00;
  // status fields
  localparam int STAT_DIR = 0;
  localparam int STAT_RTS = 1;
  localparam int STAT_RX_ON = 2;
  localparam int STAT_RXD = 3;
  // sir pulse length in 16x ticks, and the line idle level
  localparam logic [3:0] SIR_TICKS_STD = 4'h3;
  localparam logic [3:0] SIR_TICKS_FAST = 4'h4;
  localparam logic [2:0] SYNC_RST = 3'h7;
endpackage : uxf_pkg

// ### verilog/uxf_link_if.sv
// signals between the top and its multidrop filter and sir encoder
`timescale 1ns/100ps
interface uxf_link_if;
  logic ch_valid;
  logic [7:0] ch_data;
  logic ch_parity;
  logic ch_pe;
  logic multidrop;
  logic special;
  logic ls_ie;
  logic rx_on;
  logic [7:0] station;
  logic push;
  logic push_pe;
  logic [7:0] push_data;
  logic ls_req;
  logic auto_on;
  logic auto_off;
  logic sir_en;
  logic sir_fast;
  logic sir_tick;
  logic sir_txd;
  logic sir_pulse;
  modport ctl (output ch_valid, ch_data, ch_parity, ch_pe, multidrop, special, ls_ie, rx_on, station,
    sir_en, sir_fast, sir_tick, sir_txd,
    input push, push_pe, push_data, ls_req, auto_on, auto_off, sir_pulse);
  modport filt (input ch_valid, ch_data, ch_parity, ch_pe, multidrop, special, ls_ie, rx_on, station,
    output push, push_pe, push_data, ls_req, auto_on, auto_off);
  modport enc (input sir_en, sir_fast, sir_tick, sir_txd, output sir_pulse);
endinterface : uxf_link_if

// ### verilog/uxf_mdrop.sv
// receive filter for 9-bit multidrop and auto address detection
`timescale 1ns/100ps
module uxf_mdrop (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // link to the top
  uxf_link_if.filt lk
);
  typedef struct packed {
    logic push;
    logic push_pe;
    logic [7:0] push_data;
    logic ls_req;
    logic auto_on;
    logic auto_off;
  } uxf_mdrop_s;
  uxf_mdrop_s q;
  uxf_mdrop_s d;

  always_comb
  begin
    logic is_addr;
    logic hit;
    is_addr = lk.multidrop && lk.ch_parity;
    hit = lk.ch_data == lk.station;
    d = q;
    d.push = 1'b0;
    d.ls_req = 1'b0;
    d.auto_on = 1'b0;
    d.auto_off = 1'b0;
    if (lk.ch_valid)
    begin
      d.push_data = lk.ch_data;
      if (!lk.multidrop)
      begin
        d.push = lk.rx_on;
        d.push_pe = lk.ch_pe;
        d.ls_req = lk.rx_on && lk.ch_pe && lk.ls_ie;
      end
      else if (!is_addr)
      begin
        // data characters only pass while the receiver is on
        d.push = lk.rx_on;
        d.push_pe = 1'b0;
      end
      else if (!lk.special)
      begin
        d.push = 1'b1;
        d.push_pe = 1'b1;
        d.ls_req = lk.ls_ie;
      end
      else if (hit)
      begin
        d.push = 1'b1;
        d.push_pe = lk.ch_parity;
        d.ls_req = lk.ls_ie;
        d.auto_on = !lk.rx_on;
      end
      else
        d.auto_off = lk.rx_on;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      q <= '0;
    else if (clk_en)
      q <= d;
  end

  assign lk.push = q.push;
  assign lk.push_pe = q.push_pe;
  assign lk.push_data = q.push_data;
  assign lk.ls_req = q.ls_req;
  assign lk.auto_on = q.auto_on;
  assign lk.auto_off = q.auto_off;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  AST_NORMAL_PASS: assert property (clk_en && lk.ch_valid && !lk.multidrop && lk.rx_on
    |=> lk.push && lk.push_pe == $past(lk.ch_pe))
    else $error("normal mode character not pushed");
  AST_ADDR_FLAG: assert property (clk_en && lk.ch_valid && lk.multidrop && !lk.special && lk.ch_parity
    |=> lk.push && lk.push_pe && lk.ls_req == $past(lk.ls_ie))
    else $error("address character not flagged");
  AST_DATA_DROP: assert property (clk_en && lk.ch_valid && lk.multidrop && !lk.ch_parity && !lk.rx_on
    |=> !lk.push)
    else $error("data character kept while receiver off");
  AST_AUTO_HIT: assert property (clk_en && lk.ch_valid && lk.multidrop && lk.special && lk.ch_parity
    && lk.ch_data == lk.station |=> lk.push && lk.auto_on == !$past(lk.rx_on))
    else $error("matching address mishandled");
  AST_AUTO_MISS: assert property (clk_en && lk.ch_valid && lk.multidrop && lk.special && lk.ch_parity
    && lk.ch_data != lk.station |=> !lk.push && lk.auto_off == $past(lk.rx_on))
    else $error("foreign address mishandled");
  COV_AUTO_HIT: cover property (clk_en && lk.ch_valid && lk.special && lk.ch_parity ##1 lk.auto_on);
  COV_AUTO_MISS: cover property (lk.auto_off);
endmodule : uxf_mdrop

// ### verilog/uxf_sir_enc.sv
// infrared sir pulse encoder driven by the 16x baud tick
`timescale 1ns/100ps
module uxf_sir_enc (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // link to the top
  uxf_link_if.enc lk
);
  typedef struct packed {
    logic [3:0] cnt;
    logic last;
    logic pulse;
  } uxf_sir_s;
  uxf_sir_s q;
  uxf_sir_s d;
  logic [3:0] width;

  assign width = lk.sir_fast ? uxf_pkg::SIR_TICKS_FAST : uxf_pkg::SIR_TICKS_STD;

  always_comb
  begin
    d = q;
    // a level change restarts the bit; a 4-bit count wraps every 16 ticks for runs of zeros
    if (lk.sir_txd != q.last)
    begin
      d.cnt = 4'h0;
      d.last = lk.sir_txd;
    end
    else if (lk.sir_tick)
      d.cnt = q.cnt + 4'h1;
    d.pulse = lk.sir_en && !lk.sir_txd && d.cnt < width;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      q <= '{cnt: 4'h0, last: 1'b1, pulse: 1'b0};
    else if (clk_en)
      q <= d;
  end

  assign lk.sir_pulse = q.pulse;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  AST_SIR_END: assert property (clk_en && lk.sir_tick && q.cnt == width - 4'h1 && q.last == lk.sir_txd
    |=> !lk.sir_pulse)
    else $error("sir pulse longer than its ratio");
  COV_SIR: cover property (lk.sir_pulse);
endmodule : uxf_sir_enc

// ### dv/uxf_far_model.sv
// far-side model: uart core transmitter with a one-deep fifo and a 16x tick
`timescale 1ns/100ps
module uxf_far_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // bench side
  input wire logic send,
  input wire logic [7:0] send_data,
  // design side
  input wire logic tx_hold,
  output logic core_txd,
  output logic baud16_tick,
  output logic tx_fifo_push,
  output logic tx_fifo_empty,
  output logic tx_shift_empty
);
  logic full;
  logic [7:0] fifo;
  logic [9:0] sh;
  logic [3:0] nbits;
  logic [3:0] sub;
  assign core_txd = (nbits != 4'h0) ? sh[0] : 1'b1;
  assign tx_fifo_empty = ~full;
  assign tx_shift_empty = (nbits == 4'h0);
  // tick every second cycle keeps a character near 320 cycles
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      baud16_tick <= 1'b0;
      tx_fifo_push <= 1'b0;
      full <= 1'b0;
      fifo <= 8'h00;
      sh <= 10'h3FF;
      nbits <= 4'h0;
      sub <= 4'h0;
    end
    else
    begin
      baud16_tick <= ~baud16_tick;
      tx_fifo_push <= send;
      // a held transmitter leaves the next character waiting in the fifo
      if (full && nbits == 4'h0 && !tx_hold)
      begin
        sh <= {1'b1, fifo, 1'b0};
        nbits <= 4'hA;
        sub <= 4'h0;
        full <= 1'b0;
      end
      else if (nbits != 4'h0 && baud16_tick)
      begin
        sub <= sub + 4'h1;
        if (sub == 4'hF)
        begin
          sh <= {1'b1, sh[9:1]};
          nbits <= nbits - 4'h1;
        end
      end
      if (send)
      begin
        full <= 1'b1;
        fifo <= send_data;
      end
    end
  end
endmodule : uxf_far_model

// ### dv/tb_top.sv
// self-checking bench of the uart extra-features block
`timescale 1ns/100ps
module tb_top;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic core_txd, baud16_tick, tx_fifo_push, tx_fifo_empty, tx_shift_empty, tx_hold;
  logic flow_rts_n = 1'b1;
  logic char_valid = 1'b0;
  logic char_parity = 1'b0;
  logic char_pe = 1'b0;
  logic [7:0] char_data = 8'h00;
  logic rxd_core, rx_enable, rx_flush, rx_push, rx_push_pe, line_status_irq, txd_pin, rts_n_pin;
  logic [7:0] rx_push_data;
  logic rxd_pin = 1'b1;
  logic send = 1'b0;
  logic [7:0] send_data = 8'h00;
  logic [7:0] rd;
  int err_count = 0;
  int n_compared = 0;
  int cyc_count = 0;

  always #12.5 ref_clk = ~ref_clk;

  uxf_top dut (.ref_clk, .sys_rst, .clk_en, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .core_txd, .baud16_tick, .tx_fifo_push,
    .tx_fifo_empty, .tx_shift_empty, .flow_rts_n, .tx_hold, .char_valid, .char_data, .char_parity,
    .char_pe, .rxd_core, .rx_enable, .rx_flush, .rx_push, .rx_push_data, .rx_push_pe,
    .line_status_irq, .rxd_pin, .txd_pin, .rts_n_pin);

  uxf_far_model far (.ref_clk, .sys_rst, .send, .send_data, .tx_hold, .core_txd, .baud16_tick,
    .tx_fifo_push, .tx_fifo_empty, .tx_shift_empty);

  task end_of_test;
    if (err_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  task chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1)
    begin
      err_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk

  // request held until waitrequest is sampled low; slave latency is not assumed
  task bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    int n;
    @(posedge ref_clk);
    avs_address <= a;
    avs_read <= ~wr;
    avs_write <= wr;
    avs_writedata <= {24'h0, d};
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 40);
    rd = avs_readdata[7:0];
    chk(n < 40 && (wr || avs_readdata[31:8] === 24'h0), "bus access");
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task rdchk(input logic [3:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(rd === e, "read value");
  endtask : rdchk

  task send_byte(input logic [7:0] d);
    @(posedge ref_clk);
    send <= 1'b1;
    send_data <= d;
    @(posedge ref_clk);
    send <= 1'b0;
  endtask : send_byte

  task count_lvl(input logic v, input int cyc, output int n);
    n = 0;
    repeat (cyc)
    begin
      @(posedge ref_clk);
      if (txd_pin === v)
        n++;
    end
  endtask : count_lvl

  task wait_rts(input logic v, input int lim);
    int n;
    n = 0;
    while (rts_n_pin !== v && n < lim)
    begin
      @(posedge ref_clk);
      n++;
    end
    chk(rts_n_pin === v, "rts level");
  endtask : wait_rts

  // e is {pushed, parity flag, line-status request}
  task rx_char(input logic [7:0] d, input logic p, input logic [2:0] e);
    @(posedge ref_clk);
    char_valid <= 1'b1;
    char_data <= d;
    char_parity <= p;
    @(posedge ref_clk);
    char_valid <= 1'b0;
    #1;
    chk({rx_push, rx_push_pe & rx_push, line_status_irq} === e && (!e[2] || rx_push_data === d), "rx char");
  endtask : rx_char

  task t_regs;
    chk(rts_n_pin === 1'b1 && txd_pin === 1'b1 && tx_hold === 1'b0, "reset pins");
    rdchk(uxf_pkg::OFS_XFC, uxf_pkg::XFC_RST);
    bus(1'b1, uxf_pkg::OFS_XFC, 8'hFF);
    rdchk(uxf_pkg::OFS_XFC, uxf_pkg::XFC_WMASK);
    bus(1'b1, uxf_pkg::OFS_XFC, 8'h00);
    bus(1'b1, 4'h2, 8'hFF);
    rdchk(4'h2, 8'h00);
    bus(1'b1, uxf_pkg::OFS_PAUSE2, 8'hA5);
    rdchk(uxf_pkg::OFS_PAUSE2, 8'hA5);
    avs_byteenable <= 4'hE;
    bus(1'b1, uxf_pkg::OFS_PAUSE2, 8'h3C);
    avs_byteenable <= 4'hF;
    rdchk(uxf_pkg::OFS_PAUSE2, 8'hA5);
    rdchk(uxf_pkg::OFS_AUX, uxf_pkg::AUX_RST);
  endtask : t_regs

  task t_dir;
    bus(1'b1, uxf_pkg::OFS_AUX, 8'h02);
    repeat (3) @(posedge ref_clk);
    chk(rts_n_pin === 1'b0, "modem rts");
    bus(1'b1, uxf_pkg::OFS_AUX, 8'h06);
    repeat (3) @(posedge ref_clk);
    chk(rts_n_pin === 1'b1, "flow rts high");
    flow_rts_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk(rts_n_pin === 1'b0, "flow rts low");
    bus(1'b1, uxf_pkg::OFS_XFC, 8'h10);
    repeat (3) @(posedge ref_clk);
    chk(rts_n_pin === 1'b1, "tx override");
    flow_rts_n <= 1'b1;
    bus(1'b1, uxf_pkg::OFS_AUX, 8'h00);
    send_byte(8'h55);
    wait_rts(1'b0, 5);
    repeat (250) @(posedge ref_clk);
    chk(rts_n_pin === 1'b0, "rts held");
    wait_rts(1'b1, 200);
    chk(tx_shift_empty === 1'b1, "rts early");
    bus(1'b1, uxf_pkg::OFS_XFC, 8'h30);
    wait_rts(1'b0, 5);
    send_byte(8'h55);
    wait_rts(1'b1, 5);
    repeat (250) @(posedge ref_clk);
    chk(rts_n_pin === 1'b1, "inv held");
    wait_rts(1'b0, 200);
    chk(tx_shift_empty === 1'b1, "inv early");
    bus(1'b1, uxf_pkg::OFS_XFC, 8'h00);
  endtask : t_dir

  task t_txoff;
    int n;
    send_byte(8'h00);
    bus(1'b1, uxf_pkg::OFS_XFC, 8'h04);
    count_lvl(1'b0, 400, n);
    chk(tx_hold === 1'b1 && n > 260 && n < 300 && rts_n_pin === 1'b1, "char finish");
    send_byte(8'h00);
    count_lvl(1'b0, 200, n);
    chk(n == 0 && tx_fifo_empty === 1'b0, "tx idle");
    bus(1'b1, uxf_pkg::OFS_XFC, 8'h00);
    count_lvl(1'b0, 400, n);
    chk(n > 260 && n < 300, "resume");
  endtask : t_txoff

  task irda_w(input logic [7:0] x, output int n);
    bus(1'b1, uxf_pkg::OFS_XFC, x);
    send_byte(8'hFF);
    count_lvl(1'b1, 400, n);
  endtask : irda_w

  task t_irda;
    int a;
    int b;
    bus(1'b1, uxf_pkg::OFS_AUX, 8'h10);
    irda_w(8'h00, a);
    irda_w(8'h80, b);
    chk(a >= 4 && a <= 7 && b >= 6 && b <= 9 && a < b, "sir width");
    bus(1'b1, uxf_pkg::OFS_XFC, 8'h00);
  endtask : t_irda

  task t_rx_plain;
    bus(1'b1, uxf_pkg::OFS_AUX, 8'h08);
    rx_char(8'h41, 1'b1, 3'b100);
    char_pe <= 1'b1;
    rx_char(8'h42, 1'b0, 3'b111);
    char_pe <= 1'b0;
    bus(1'b1, uxf_pkg::OFS_XFC, 8'h02);
    @(posedge ref_clk);
    chk(rx_enable === 1'b0 && rx_flush === 1'b1, "rx off");
    rx_char(8'h43, 1'b0, 3'b000);
    bus(1'b1, uxf_pkg::OFS_XFC, 8'h00);
    rxd_pin <= 1'b0;
    repeat (5) @(posedge ref_clk);
    chk(rxd_core === 1'b0, "rxd sync");
    rxd_pin <= 1'b1;
  endtask : t_rx_plain

  task t_mdrop;
    logic f;
    f = 1'b0;
    bus(1'b1, uxf_pkg::OFS_XFC, 8'h03);
    repeat (3)
    begin
      @(posedge ref_clk);
      f = f | rx_flush;
    end
    chk(f === 1'b1, "flush");
    rx_char(8'h10, 1'b0, 3'b000);
    rx_char(8'h22, 1'b1, 3'b111);
    bus(1'b1, uxf_pkg::OFS_AUX, 8'h00);
    rx_char(8'h23, 1'b1, 3'b110);
    bus(1'b1, uxf_pkg::OFS_AUX, 8'h08);
    bus(1'b1, uxf_pkg::OFS_XFC, 8'h01);
    rx_char(8'h33, 1'b0, 3'b100);
    rx_char(8'h44, 1'b1, 3'b111);
    rx_char(8'h55, 1'b0, 3'b100);
  endtask : t_mdrop

  task t_auto;
    bus(1'b1, uxf_pkg::OFS_PAUSE2, 8'h5A);
    bus(1'b1, uxf_pkg::OFS_AUX, 8'h09);
    bus(1'b1, uxf_pkg::OFS_XFC, 8'h03);
    rx_char(8'h5A, 1'b0, 3'b000);
    rx_char(8'h33, 1'b1, 3'b000);
    rx_char(8'h5A, 1'b1, 3'b111);
    repeat (2) @(posedge ref_clk);
    bus(1'b0, uxf_pkg::OFS_STAT, 8'h00);
    chk(rd[uxf_pkg::STAT_RX_ON] === 1'b1, "auto on");
    rx_char(8'h66, 1'b0, 3'b100);
    rx_char(8'h33, 1'b1, 3'b000);
    rx_char(8'h66, 1'b0, 3'b000);
    rdchk(uxf_pkg::OFS_XFC, 8'h03);
    rx_char(8'h5A, 1'b1, 3'b111);
    rx_char(8'h5A, 1'b1, 3'b111);
  endtask : t_auto

  // a whole run needs under 6000 cycles
  always @(posedge ref_clk)
  begin
    cyc_count++;
    if (cyc_count == 20000)
    begin
      err_count++;
      end_of_test();
    end
  end

  initial
  begin
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    t_regs();
    t_dir();
    t_txoff();
    t_irda();
    t_rx_plain();
    t_mdrop();
    t_auto();
    end_of_test();
  end
endmodule : tb_top
